// ---- design/ptl_defs.vh ----
`ifndef PTL_DEFS_VH
`define PTL_DEFS_VH
// What this block does
// - target finishes first data phase within 16 clocks, later within 8.
// - read word moves in on the clock local ready and acknowledge coincide.
// - local address output steps by 4 after each local word transfer.
// - read word reaches the bus two clocks after capture, with target ready.
// - local read wait shows later as target ready deasserted on the bus.
// - master wait drops local acknowledge at once and holds bus data.
// - bursts run without inserted waits and have no length limit.
// - config read claimed by ID select, data supplied without local side.
// - write hit signals claim locally and drives address and command out.
// - latched address decoded against base ranges in the clock after address.
// - clock 4 enables select, ready, stop drivers; select asserted clock 5.
// - write ready asserted clock 6; data captured when both readies assert.
// - write word reaches local side the clock after ready and acknowledge.
// - write data and enables driven out; frame and hit dropped at completion.
// - on reads, device acknowledge means room for a word; local ready means data valid.
// - slow decode, device select three clocks after the address.
// - claimed non-config transactions drive exactly one of six range hit outputs.

`define PTL_CMD_IO_RD 4'h2
`define PTL_CMD_IO_WR 4'h3
`define PTL_CMD_MEM_RD 4'h6
`define PTL_CMD_MEM_WR 4'h7
`define PTL_CMD_CFG_RD 4'ha
`define PTL_CMD_MEM_RD_MUL 4'hc
`define PTL_CMD_MEM_RD_LINE 4'he
`define PTL_CMD_MEM_WR_INV 4'hf

`define PTL_ADDR_STEP 32'h0000_0004
`define PTL_LAT_FIRST 5'h10
`define PTL_LAT_NEXT 5'h08
// data state opens three clocks into the first phase, so it gets more slack
`define PTL_LAT_FIRST_SLACK 5'h05
`define PTL_LAT_NEXT_SLACK 5'h02
`define PTL_CFG_IDX_MSB 7
`define PTL_CFG_IDX_LSB 2
`define PTL_NUM_BARS 6
`endif

// ---- design/ptl_target.v ----
`timescale 1ns/100ps
`include "ptl_defs.vh"

// ----------------------------------------
// data fifo
// ----------------------------------------
module ptl_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_flush,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire [AW:0] o_count
);
    localparam [AW:0] FULL = DEPTH;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign o_in_ready = (count_q != FULL);
    assign o_out_valid = (count_q != {(AW+1){1'b0}});
    assign push = i_in_valid & o_in_ready;
    assign pop = i_out_ready & o_out_valid;
    assign o_out_data = mem[rd_ptr_q];
    assign o_count = count_q;

    always @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_in_data;
        end
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else if (i_flush) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ----------------------------------------
// target transfer engine
// ----------------------------------------
module ptl_target #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4,
    parameter [191:0] BAR_BASE = 192'h0,
    parameter [191:0] BAR_MASK = 192'h0
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_frame_n,
    input wire i_irdy_n,
    input wire i_idsel,
    input wire [31:0] i_ad,
    input wire [3:0] i_cbe_n,
    output reg [31:0] o_ad,
    output reg o_ad_oe_n,
    output reg o_devsel_n,
    output reg o_trdy_n,
    output reg o_stop_n,
    output reg o_ctl_oe_n,
    output reg o_local_frame_ind_n,
    output reg [5:0] o_bar_hit,
    output reg [31:0] o_local_address_out,
    output reg [3:0] o_local_command_out,
    output wire o_local_acknowledge_n,
    input wire i_local_ready_n,
    input wire [31:0] i_local_read_data_in,
    output reg [31:0] o_local_write_data_out,
    output reg [3:0] o_local_byte_enable_out,
    input wire i_local_disconnect_req_n,
    output wire [5:0] o_cfg_dword_index,
    input wire [31:0] i_cfg_data
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DECODE = 3'h1;
    localparam [2:0] ST_CLAIM = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_STOP = 3'h4;
    localparam [2:0] ST_TURN = 3'h5;
    localparam [FIFO_AW:0] ROOM_MAX = FIFO_DEPTH - 2;

    reg [2:0] state_q;
    reg [31:0] addr_q;
    reg [3:0] cmd_q;
    reg idsel_q;
    reg is_wr_q;
    reg is_cfg_q;
    reg pci_done_q;
    reg first_q;
    reg [4:0] lat_cnt_q;

    wire [5:0] hits;
    wire [5:0] hit_oh;
    wire rd_cmd;
    wire wr_cmd;
    wire cfg_hit;
    wire taken;
    wire in_data;
    wire rd_phase;
    wire wr_local;
    wire local_xfer;
    wire lat_over;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [35:0] fifo_in_data;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [35:0] fifo_out_data;
    wire [FIFO_AW:0] fifo_count;
    wire rd_load;
    wire last_wr_pop;
    wire wr_go = ~i_local_ready_n & (fifo_count <= ROOM_MAX);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PTL_NUM_BARS; g = g + 1) begin : g_bar
            assign hits[g] = (BAR_MASK[g*32 +: 32] != 32'h0) &
                ((addr_q & BAR_MASK[g*32 +: 32]) == BAR_BASE[g*32 +: 32]);
        end
    endgenerate
    // lowest matching range wins so only one hit line rises
    assign hit_oh = hits & (~hits + 6'h01);

    assign rd_cmd = (cmd_q == `PTL_CMD_MEM_RD) | (cmd_q == `PTL_CMD_MEM_RD_MUL) |
        (cmd_q == `PTL_CMD_MEM_RD_LINE) | (cmd_q == `PTL_CMD_IO_RD);
    assign wr_cmd = (cmd_q == `PTL_CMD_MEM_WR) | (cmd_q == `PTL_CMD_MEM_WR_INV) |
        (cmd_q == `PTL_CMD_IO_WR);
    // config writes are not claimed here
    assign cfg_hit = idsel_q & (cmd_q == `PTL_CMD_CFG_RD);
    assign o_cfg_dword_index = addr_q[`PTL_CFG_IDX_MSB:`PTL_CFG_IDX_LSB];

    // ----------------------------------------
    // handshakes
    // ----------------------------------------
    assign in_data = (state_q == ST_DATA);
    assign taken = ~o_trdy_n & ~i_irdy_n;
    assign rd_phase = in_data & ~is_wr_q & ~is_cfg_q;
    assign wr_local = is_wr_q & ~o_local_frame_ind_n;
    // acknowledge drops in the same clock the master pauses
    assign o_local_acknowledge_n = ~((rd_phase & fifo_in_ready & ~i_irdy_n) |
        (wr_local & fifo_out_valid));
    assign local_xfer = ~o_local_acknowledge_n & ~i_local_ready_n;

    assign fifo_in_valid = (rd_phase & local_xfer) | (in_data & is_wr_q & taken);
    assign fifo_in_data = is_wr_q ? {i_cbe_n, i_ad} : {4'h0, i_local_read_data_in};
    // fifo storage is the first pipe stage, o_ad the second
    assign rd_load = rd_phase & fifo_out_valid & (o_trdy_n | taken) &
        ~(taken & i_frame_n);
    assign fifo_out_ready = rd_load | (wr_local & local_xfer);
    assign last_wr_pop = wr_local & local_xfer & pci_done_q &
        (fifo_count == {{FIFO_AW{1'b0}}, 1'b1});
    assign lat_over = o_trdy_n & ~(is_wr_q ? wr_go : rd_load) &
        (lat_cnt_q >= (first_q ? (`PTL_LAT_FIRST - `PTL_LAT_FIRST_SLACK) :
        (`PTL_LAT_NEXT - `PTL_LAT_NEXT_SLACK)));

    ptl_fifo #(
        .WIDTH(36),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_flush((state_q == ST_TURN) & ~is_wr_q),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data),
        .o_count(fifo_count)
    );

    // ----------------------------------------
    // bus sequencer
    // ----------------------------------------
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            addr_q <= 32'h0;
            cmd_q <= 4'h0;
            idsel_q <= 1'b0;
            is_wr_q <= 1'b0;
            is_cfg_q <= 1'b0;
            pci_done_q <= 1'b0;
            first_q <= 1'b1;
            lat_cnt_q <= 5'h00;
            o_ad <= 32'h0;
            o_ad_oe_n <= 1'b1;
            o_devsel_n <= 1'b1;
            o_trdy_n <= 1'b1;
            o_stop_n <= 1'b1;
            o_ctl_oe_n <= 1'b1;
            o_local_frame_ind_n <= 1'b1;
            o_bar_hit <= 6'h00;
            o_local_address_out <= 32'h0;
            o_local_command_out <= 4'h0;
            o_local_write_data_out <= 32'h0;
            o_local_byte_enable_out <= 4'h0;
        end else begin
            if (local_xfer) begin
                o_local_address_out <= o_local_address_out + `PTL_ADDR_STEP;
            end
            if (wr_local & local_xfer) begin
                o_local_write_data_out <= fifo_out_data[31:0];
                o_local_byte_enable_out <= ~fifo_out_data[35:32];
            end
            if (last_wr_pop) begin
                o_local_frame_ind_n <= 1'b1;
                o_bar_hit <= 6'h00;
                pci_done_q <= 1'b0;
            end
            if (in_data) begin
                if (taken) begin
                    lat_cnt_q <= 5'h00;
                    first_q <= 1'b0;
                end else begin
                    lat_cnt_q <= lat_cnt_q + 5'h01;
                end
            end
            case (state_q)
                ST_IDLE: begin
                    o_ctl_oe_n <= 1'b1;
                    o_ad_oe_n <= 1'b1;
                    // a new cycle waits until the previous write has drained
                    if (~i_frame_n & o_local_frame_ind_n) begin
                        addr_q <= i_ad;
                        cmd_q <= i_cbe_n;
                        idsel_q <= i_idsel;
                        state_q <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    is_wr_q <= wr_cmd;
                    is_cfg_q <= cfg_hit;
                    first_q <= 1'b1;
                    lat_cnt_q <= 5'h00;
                    if (cfg_hit | (~idsel_q & (hit_oh != 6'h00) & (rd_cmd | wr_cmd))) begin
                        state_q <= ST_CLAIM;
                        o_ctl_oe_n <= 1'b0;
                        if (~cfg_hit) begin
                            o_local_frame_ind_n <= 1'b0;
                            o_bar_hit <= hit_oh;
                            o_local_address_out <= addr_q;
                            o_local_command_out <= cmd_q;
                        end
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_CLAIM: begin
                    state_q <= ST_DATA;
                    o_devsel_n <= 1'b0;
                    o_ad_oe_n <= is_wr_q;
                end
                ST_DATA: begin
                    if (taken & i_frame_n) begin
                        state_q <= ST_TURN;
                        o_trdy_n <= 1'b1;
                        o_devsel_n <= 1'b1;
                        pci_done_q <= is_wr_q;
                    end else if (~is_cfg_q & (~i_local_disconnect_req_n | lat_over)) begin
                        // disconnect without data; no further phase completes
                        state_q <= ST_STOP;
                        o_trdy_n <= 1'b1;
                        o_stop_n <= 1'b0;
                    end else if (is_cfg_q) begin
                        if (o_trdy_n) begin
                            o_ad <= i_cfg_data;
                            o_trdy_n <= 1'b0;
                        end
                    end else if (is_wr_q) begin
                        // room for the word in flight plus the next one
                        o_trdy_n <= ~wr_go;
                    end else begin
                        if (rd_load) begin
                            o_ad <= fifo_out_data[31:0];
                        end
                        // held data stays on the bus while the master waits
                        o_trdy_n <= ~(rd_load | (~o_trdy_n & ~taken));
                    end
                end
                ST_STOP: begin
                    if (i_frame_n) begin
                        state_q <= ST_TURN;
                        o_stop_n <= 1'b1;
                        o_devsel_n <= 1'b1;
                        pci_done_q <= is_wr_q;
                    end
                end
                ST_TURN: begin
                    state_q <= ST_IDLE;
                    o_ad_oe_n <= 1'b1;
                    o_stop_n <= 1'b1;
                    if (~is_wr_q | (fifo_count == {(FIFO_AW+1){1'b0}})) begin
                        o_local_frame_ind_n <= 1'b1;
                        o_bar_hit <= 6'h00;
                        pci_done_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- design/ptl_target_unused_placeholder_removed.v ----
`timescale 1ns/100ps

// ---- tb/ptl_local_app.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// local application model
// ----------------------------------------
module ptl_la_model #(
    parameter [31:0] PAT = 32'h5a3c_0000
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_frame_ind_n,
    input wire [31:0] i_addr,
    input wire i_stall,
    input wire i_hold,
    input wire i_disc,
    output reg o_ready_n,
    output wire [31:0] o_rdata,
    output wire o_disc_n
);
    reg tog_q;
    // a stall waits every other clock, well inside the word budget
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_q <= 1'b0;
            o_ready_n <= 1'b1;
        end else begin
            tog_q <= ~tog_q;
            o_ready_n <= i_frame_ind_n | i_hold | (i_stall & tog_q);
        end
    end
    // invalid data is shown inverted so a stale word never matches
    assign o_rdata = o_ready_n ? ~(i_addr ^ PAT) : (i_addr ^ PAT);
    assign o_disc_n = ~i_disc;
endmodule

// ---- tb/ptl_target_asserts.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module ptl_target_chk (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_frame_n,
    input wire i_irdy_n,
    input wire [31:0] o_ad,
    input wire o_ad_oe_n,
    input wire o_devsel_n,
    input wire o_trdy_n,
    input wire o_stop_n,
    input wire o_ctl_oe_n,
    input wire o_local_frame_ind_n,
    input wire [5:0] o_bar_hit,
    input wire [31:0] o_local_address_out,
    input wire o_local_acknowledge_n,
    input wire i_local_ready_n,
    input wire [31:0] i_local_read_data_in
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire take = !o_local_acknowledge_n && !i_local_ready_n;
    wire bus_xfer = !o_trdy_n && !i_irdy_n && !o_ad_oe_n;
    reg [5:0] pend_q;
    // read latency is only fixed while the pipeline is empty
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_q <= 6'h00;
        end else if (o_ctl_oe_n) begin
            pend_q <= 6'h00;
        end else begin
            pend_q <= pend_q + {5'h00, take & !o_ad_oe_n} - {5'h00, bus_xfer};
        end
    end
    chk_decode_slot: assert property ($fell(o_ctl_oe_n) |->
        $past(i_frame_n, 3) && !$past(i_frame_n, 2)) else $error("claim off slot");
    chk_devsel_next: assert property ($fell(o_ctl_oe_n) |=> $fell(o_devsel_n))
        else $error("select not one clock after enable");
    chk_devsel_slow: assert property ($fell(o_devsel_n) |->
        $past(i_frame_n, 4) && !$past(i_frame_n, 3)) else $error("select not slow decode");
    chk_first_phase: assert property ($fell(o_devsel_n) |->
        ##[0:12] (!o_trdy_n || !o_stop_n)) else $error("first phase too slow");
    chk_addr_step: assert property (!o_local_frame_ind_n && take |=>
        o_local_address_out == $past(o_local_address_out) + 32'h4) else $error("no step");
    chk_read_pipe: assert property (take && !o_ad_oe_n && pend_q == 6'h00 |->
        ##2 (!o_stop_n || (!o_trdy_n && o_ad == $past(i_local_read_data_in, 2))))
        else $error("read word late");
    chk_wait_ack: assert property (!o_ad_oe_n && i_irdy_n |-> o_local_acknowledge_n)
        else $error("ack during master wait");
    chk_hold_word: assert property (!o_trdy_n && i_irdy_n && !o_ad_oe_n |=>
        !o_trdy_n && $stable(o_ad)) else $error("word not held");
    chk_bar_hit: assert property (o_local_frame_ind_n ? o_bar_hit == 6'h00 :
        $onehot(o_bar_hit)) else $error("range hit not one-hot");
    chk_ctl_enabled: assert property (!o_devsel_n |-> !o_ctl_oe_n)
        else $error("select without driver");
    cover property ($fell(o_devsel_n) && !o_local_frame_ind_n && !o_ad_oe_n);
    cover property (!o_trdy_n && i_irdy_n && !o_ad_oe_n);
    cover property (take && o_ad_oe_n && !o_local_frame_ind_n);
    cover property ($fell(o_devsel_n) && o_local_frame_ind_n);
    cover property ($fell(o_stop_n) && !o_local_frame_ind_n);
endmodule

bind ptl_target ptl_target_chk u_ptl_target_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_frame_n(i_frame_n), .i_irdy_n(i_irdy_n),
    .o_ad(o_ad), .o_ad_oe_n(o_ad_oe_n), .o_devsel_n(o_devsel_n), .o_trdy_n(o_trdy_n),
    .o_stop_n(o_stop_n), .o_ctl_oe_n(o_ctl_oe_n), .o_local_frame_ind_n(o_local_frame_ind_n),
    .o_bar_hit(o_bar_hit), .o_local_address_out(o_local_address_out),
    .o_local_acknowledge_n(o_local_acknowledge_n), .i_local_ready_n(i_local_ready_n),
    .i_local_read_data_in(i_local_read_data_in)
);

// ---- tb/test_pci_target_local_transfer.sv ----
`timescale 1ns/100ps
`include "ptl_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module test_pci_target_local_transfer;
    localparam [31:0] PAT = 32'h5a3c_0000;
    localparam [31:0] BAR0 = 32'h1000_0000;
    localparam [31:0] BAR1 = 32'h2000_0000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic frame_n = 1'b1;
    logic irdy_n = 1'b1;
    logic idsel = 1'b0;
    logic stall = 1'b0;
    logic hold = 1'b0;
    logic disc = 1'b0;
    logic [31:0] ad = 32'h0;
    logic [3:0] cbe_n = 4'hf;
    logic [31:0] cfg_data = 32'h0;
    wire [31:0] o_ad, laddr, rdata, wdata;
    wire [5:0] hit, cfg_idx;
    wire [3:0] lcmd, ben;
    wire ad_oe_n, devsel_n, trdy_n, stop_n, ctl_oe_n, frame_ind_n, ack_n, ready_n, disc_n;
    int errors = 0;
    int samples_checked = 0;

    ptl_target #(.BAR_BASE({128'h0, BAR1, BAR0}), .BAR_MASK({128'h0, {2{32'hffff_0000}}}))
    u_ptl_target (.i_core_clk(clk), .i_rst(rst), .i_frame_n(frame_n), .i_irdy_n(irdy_n),
        .i_idsel(idsel), .i_ad(ad), .i_cbe_n(cbe_n), .o_ad(o_ad), .o_ad_oe_n(ad_oe_n),
        .o_devsel_n(devsel_n), .o_trdy_n(trdy_n), .o_stop_n(stop_n), .o_ctl_oe_n(ctl_oe_n),
        .o_local_frame_ind_n(frame_ind_n), .o_bar_hit(hit), .o_local_address_out(laddr),
        .o_local_command_out(lcmd), .o_local_acknowledge_n(ack_n), .i_local_ready_n(ready_n),
        .i_local_read_data_in(rdata), .o_local_write_data_out(wdata),
        .o_local_byte_enable_out(ben), .i_local_disconnect_req_n(disc_n),
        .o_cfg_dword_index(cfg_idx), .i_cfg_data(cfg_data));
    ptl_la_model #(.PAT(PAT)) u_ptl_la_model (.i_core_clk(clk), .i_rst(rst),
        .i_frame_ind_n(frame_ind_n), .i_addr(laddr), .i_stall(stall), .i_hold(hold),
        .i_disc(disc), .o_ready_n(ready_n), .o_rdata(rdata), .o_disc_n(disc_n));

    initial forever #25 clk = ~clk;

    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic addr_ph(input [31:0] a, input [3:0] c, input bit id, input bit st,
            input [31:0] d, input [3:0] be_n);
        @(posedge clk);
        frame_n <= 1'b0;
        ad <= a;
        cbe_n <= c;
        idsel <= id;
        stall <= st;
        @(posedge clk);
        idsel <= 1'b0;
        irdy_n <= 1'b0;
        ad <= d;
        cbe_n <= be_n;
    endtask

    task automatic rd_burst(input [31:0] a, input [3:0] c, input int n, input bit st,
            input bit iw, input [5:0] h);
        int k, idle, t;
        bit w;
        k = 0;
        idle = 0;
        w = 0;
        addr_ph(a, c, 1'b0, st, ~a, 4'h0);
        frame_n <= (n == 1);
        for (t = 0; t < 80 && k < n; t++) begin
            @(negedge clk);
            if (!irdy_n && !trdy_n) begin
                if (k == 0) `CHK(hit, h)
                `CHK(o_ad, (a + 32'h4 * k) ^ PAT)
                k++;
            end else if (k > 0 && !irdy_n) idle++;
            @(posedge clk);
            if (iw && k == 2 && !w) begin
                irdy_n <= 1'b1;
                w = 1;
            end else irdy_n <= (k >= n);
            frame_n <= (k >= n - 1);
        end
        `CHK(k, n)
        `CHK(idle != 0, st)
        repeat (3) @(posedge clk);
        `CHK(hit, 6'h00)
    endtask

    task automatic wr_one(input [31:0] a, input [3:0] c, input [31:0] d, input [3:0] be,
            input [5:0] h);
        int t;
        addr_ph(a, c, 1'b0, 1'b0, d, ~be);
        frame_n <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(negedge clk);
            if (!trdy_n) break;
        end
        `CHK(t, 3)
        `CHK(hit, h)
        `CHK({laddr, lcmd}, {a, c})
        @(posedge clk);
        irdy_n <= 1'b1;
        ad <= ~d;
        for (t = 0; t < 20; t++) begin
            @(negedge clk);
            if (frame_ind_n) break;
        end
        `CHK(t, 1)
        `CHK({wdata, ben}, {d, be})
        `CHK({laddr, hit}, {a + 32'h4, 6'h00})
        repeat (3) @(posedge clk);
    endtask

    task automatic cfg_rd;
        int t;
        cfg_data <= 32'hc0f1_9a5e;
        addr_ph(32'h0000_0014, `PTL_CMD_CFG_RD, 1'b1, 1'b0, ~32'h0000_0014, 4'h0);
        frame_n <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(negedge clk);
            `CHK(frame_ind_n, 1'b1)
            if (!trdy_n) break;
        end
        `CHK({t, o_ad, cfg_idx}, {32'd3, 32'hc0f1_9a5e, 6'h05})
        @(posedge clk);
        irdy_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // local side ends a read: by request, or by never supplying a word
    task automatic term_rd(input bit dsc);
        int t;
        addr_ph(BAR0 + 32'h100, `PTL_CMD_MEM_RD, 1'b0, 1'b0, ~(BAR0 + 32'h100), 4'h0);
        if (dsc) disc <= 1'b1;
        else hold <= 1'b1;
        for (t = 0; t < 30; t++) begin
            @(negedge clk);
            if (!stop_n) break;
        end
        `CHK(t, dsc ? 3 : `PTL_LAT_FIRST - 2)
        `CHK({trdy_n, devsel_n}, 2'h2)
        @(posedge clk);
        frame_n <= 1'b1;
        disc <= 1'b0;
        hold <= 1'b0;
        @(posedge clk);
        irdy_n <= 1'b1;
        @(negedge clk);
        `CHK({stop_n, devsel_n}, 2'h3)
        repeat (3) @(posedge clk);
        `CHK({frame_ind_n, hit}, 7'h40)
    endtask

    task automatic miss_rd;
        addr_ph(32'h3000_0000, `PTL_CMD_MEM_RD, 1'b0, 1'b0, ~32'h3000_0000, 4'h0);
        frame_n <= 1'b1;
        repeat (6) begin
            @(negedge clk);
            `CHK({ctl_oe_n, frame_ind_n}, 2'h3)
        end
        @(posedge clk);
        irdy_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_burst(BAR0, `PTL_CMD_MEM_RD, 1, 1'b0, 1'b0, 6'h01);
        rd_burst(BAR0 + 32'h40, `PTL_CMD_MEM_RD_MUL, 6, 1'b0, 1'b1, 6'h01);
        rd_burst(BAR1 + 32'h80, `PTL_CMD_MEM_RD_LINE, 5, 1'b1, 1'b0, 6'h02);
        rd_burst(BAR1 + 32'h8, `PTL_CMD_IO_RD, 1, 1'b0, 1'b0, 6'h02);
        wr_one(BAR0 + 32'h8, `PTL_CMD_MEM_WR, 32'hdead_0001, 4'h5, 6'h01);
        wr_one(BAR1 + 32'hc, `PTL_CMD_IO_WR, 32'h1234_5678, 4'ha, 6'h02);
        wr_one(BAR0 + 32'h20, `PTL_CMD_MEM_WR_INV, 32'h0bad_f00d, 4'hf, 6'h01);
        term_rd(1'b1);
        term_rd(1'b0);
        cfg_rd;
        miss_rd;
        report_and_stop;
    end

    initial begin
        #(50 * 3000);
        errors++;
        report_and_stop;
    end
endmodule
